// ==== hw/rlc_pkg.sv ====
package rlc_pkg;
	// bus timing and identity
	localparam int CLK_HZ = 200_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam logic [6:0] SMB_DEV_ADDR = 7'h5A; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// register offsets
	localparam logic [7:0] OFS_SWING = 8'h25;
	localparam logic [7:0] OFS_DEEMPH = 8'h26;
	localparam logic [7:0] OFS_IDLE_THR = 8'h27;
	localparam logic [7:0] OFS_SD_CTL = 8'h28;
	localparam logic [7:0] OFS_RSV_A = 8'h29;
	localparam logic [7:0] OFS_RSV_B = 8'h2A;
	localparam logic [7:0] OFS_A0_IDLE = 8'h2B;

	// reset values
	localparam logic [7:0] RST_SWING = 8'hAD;
	localparam logic [4:0] RST_DEEMPH = 5'h02;
	localparam logic [7:0] RST_IDLE_THR = 8'h00;
	localparam logic [7:0] RST_SD_CTL = 8'h0C;
	localparam logic [7:0] RST_RSV = 8'h00;
	localparam logic [7:0] RST_A0_IDLE = 8'h00;

	// field positions
	localparam int SWING_SCP_BIT = 7;
	localparam int SWING_RATE_BIT = 6;
	localparam int IDLE_AUTO_BIT = 5;
	localparam int IDLE_SEL_BIT = 4;
	localparam int FAR_RECEIVER_PROBE_LSB = 2;

	// receiver-detect modes
	localparam logic [1:0] FAR_RECEIVER_PROBE_HIZ = 2'h0;
	localparam logic [1:0] FAR_RECEIVER_PROBE_PROBE_LIMITED = 2'h1;
	localparam logic [1:0] FAR_RECEIVER_PROBE_PROBE_FOREVER = 2'h2;
	localparam logic [1:0] FAR_RECEIVER_PROBE_FIXED_50 = 2'h3;

	// receiver probe timing
	localparam int PROBE_PERIOD_MS = 12;
	localparam int PROBE_WINDOW_MS = 600;
	localparam int PROBE_PERIOD_CYCLES = PROBE_PERIOD_MS * CLK_PER_MS;
	localparam logic [5:0] PROBE_LIMIT = 6'(PROBE_WINDOW_MS / PROBE_PERIOD_MS);

	// target state machine, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_ACK = 6'h04,
		ST_SEND = 6'h08,
		ST_MACK = 6'h10,
		ST_SKIP = 6'h20
	} rlc_state_e;

	typedef enum logic [1:0] {
		BYTE_ADDR = 2'h0,
		BYTE_OFFS = 2'h1,
		BYTE_DATA = 2'h2
	} rlc_kind_e;
endpackage

// ==== hw/rlc_regs.sv ====
// How it works
// RQ1: swing bit 7 enables short-circuit protection
// RQ2: swing bit 6 overrides rate pin
// RQ3: host writes reserved swing bits as 101
// RQ4: swing bits 2:0 pick 0.7-1.4 V
// RQ5: de-emphasis bit 7 reads far receiver present
// RQ6: de-emphasis bits 6:5 read detected rate
// RQ7: de-emphasis bits 2:0 pick 0 to -12 dB
// RQ8: threshold bits 3:2 set idle assert level
// RQ9: threshold bits 1:0 set idle deassert level
// RQ10: shared bits 5:4 raise detect threshold range
// RQ11: shared bits 3:2 enable fast detection
// RQ12: shared bits 1:0 reduce detect gain
// RQ13: idle bit 5 hands idle to bit 4
// RQ14: manual bit 4 mutes output into idle
// RQ15: idle bits 3:2 choose receiver detection mode
// RQ16: writes to status bits ignored, reads live
module rlc_regs #(
	parameter int PROBE_CYCLES = rlc_pkg::PROBE_PERIOD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic smb_scl,
	input wire logic smb_sda_in,
	output logic smb_sda_out,
	output logic smb_sda_oe_n,
	input wire logic lane_b3_far_rx_present,
	input wire logic [1:0] lane_b3_observed_line_rate,
	input wire logic lane_a0_far_rx_present,
	input wire logic lane_a0_idle_seen,
	output logic lane_b3_short_protect_en,
	output logic lane_b3_rate_gen12,
	output logic [2:0] lane_b3_output_swing_level,
	output logic [2:0] lane_b3_deemphasis_level,
	output logic [1:0] lane_b3_idle_assert_thr,
	output logic [1:0] lane_b3_idle_deassert_thr,
	output logic [1:0] sd_high_range,
	output logic [1:0] sd_fast_detect,
	output logic [1:0] sd_reduced_gain,
	output logic lane_a0_output_mute,
	output logic lane_a0_term_50ohm,
	output logic lane_a0_far_receiver_probe
);
	import rlc_pkg::*;

	// two-flop synchronisers for every pin input
	localparam int NSYNC = 7;
	// bus pins idle high, lane status idle low: no false edge or mute after reset
	localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h60;
	logic [NSYNC-1:0] sync_raw;
	logic [NSYNC-1:0] sync_1;
	logic [NSYNC-1:0] sync_2;
	assign sync_raw = {smb_scl, smb_sda_in, lane_b3_far_rx_present, lane_b3_observed_line_rate,
		lane_a0_far_rx_present, lane_a0_idle_seen};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					sync_1[gi] <= SYNC_IDLE[gi];
					sync_2[gi] <= SYNC_IDLE[gi];
				end else begin
					sync_1[gi] <= sync_raw[gi];
					sync_2[gi] <= sync_1[gi];
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic b3_rx_s;
	logic [1:0] b3_rate_s;
	logic a0_rx_s;
	logic a0_idle_s;
	assign {scl_s, sda_s, b3_rx_s, b3_rate_s, a0_rx_s, a0_idle_s} = sync_2;

	logic scl_p;
	logic sda_p;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	logic bus_start;
	logic bus_stop;
	logic scl_rise;
	logic scl_fall;
	assign bus_start = scl_s && scl_p && sda_p && !sda_s;
	assign bus_stop = scl_s && scl_p && !sda_p && sda_s;
	assign scl_rise = scl_s && !scl_p;
	assign scl_fall = !scl_s && scl_p;

	// register storage
	logic [7:0] swing;
	logic [4:0] deemph_ctl;
	logic [7:0] idle_thr;
	logic [7:0] sd_ctl;
	logic [7:0] rsv_a;
	logic [7:0] rsv_b;
	logic [7:0] a0_idle;

	// status bits come from the live synchronised inputs, never from storage
	function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
		case (ofs)
			OFS_SWING: rd_mux = swing;
			OFS_DEEMPH: rd_mux = {b3_rx_s, b3_rate_s, deemph_ctl}; // RQ5 RQ6 RQ16
			OFS_IDLE_THR: rd_mux = idle_thr;
			OFS_SD_CTL: rd_mux = sd_ctl;
			OFS_RSV_A: rd_mux = rsv_a;
			OFS_RSV_B: rd_mux = rsv_b;
			OFS_A0_IDLE: rd_mux = a0_idle;
			default: rd_mux = 8'h00;
		endcase
	endfunction

	// smbus target
	rlc_state_e state;
	rlc_kind_e kind;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic [7:0] ptr;
	logic rd_mode;
	logic host_nack;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] next_byte;
	// process form so that storage read inside the function also wakes it
	always_comb begin
		next_byte = rd_mux(ptr);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			kind <= BYTE_ADDR;
			shreg <= 8'h00;
			bit_cnt <= 4'h0;
			ptr <= 8'h00;
			rd_mode <= 1'b0;
			host_nack <= 1'b0;
			smb_sda_oe_n <= 1'b1;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (bus_start) begin
				state <= ST_RECV;
				kind <= BYTE_ADDR;
				bit_cnt <= 4'h0;
				smb_sda_oe_n <= 1'b1;
			end else if (bus_stop) begin
				state <= ST_IDLE;
				smb_sda_oe_n <= 1'b1;
			end else begin
				case (state)
					ST_IDLE, ST_SKIP: begin
						smb_sda_oe_n <= 1'b1;
					end
					ST_RECV: begin
						if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
							shreg <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
							state <= ST_ACK;
							smb_sda_oe_n <= 1'b0;
							case (kind)
								BYTE_ADDR: begin
									if (shreg[7:1] == SMB_DEV_ADDR) begin
										rd_mode <= shreg[0];
									end else begin
										// not our address: stay off the wire until the next start
										state <= ST_SKIP;
										smb_sda_oe_n <= 1'b1;
									end
									kind <= BYTE_OFFS;
								end
								BYTE_OFFS: begin
									ptr <= shreg;
									kind <= BYTE_DATA;
								end
								default: begin
									wr_stb <= 1'b1;
									wr_addr <= ptr;
									wr_data <= shreg;
									ptr <= ptr + 8'h01;
								end
							endcase
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (rd_mode) begin
								state <= ST_SEND;
								shreg <= next_byte;
								ptr <= ptr + 8'h01;
								smb_sda_oe_n <= next_byte[7];
							end else begin
								state <= ST_RECV;
								smb_sda_oe_n <= 1'b1;
							end
						end
					end
					ST_SEND: begin
						if (scl_fall) begin
							if (bit_cnt == LAST_TX_BIT) begin
								state <= ST_MACK;
								smb_sda_oe_n <= 1'b1;
							end else begin
								shreg <= {shreg[6:0], 1'b0};
								smb_sda_oe_n <= shreg[6];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							host_nack <= sda_s;
						end else if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (host_nack) begin
								state <= ST_SKIP;
							end else begin
								state <= ST_SEND;
								shreg <= next_byte;
								ptr <= ptr + 8'h01;
								smb_sda_oe_n <= next_byte[7];
							end
						end
					end
					default: begin
						state <= ST_IDLE;
						smb_sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// open drain: only the enable moves
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			smb_sda_out <= 1'b0;
		end else begin
			smb_sda_out <= 1'b0;
		end
	end

	// register writes; reserved swing bits kept as written, host must keep 101
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			swing <= RST_SWING; // RQ4
			deemph_ctl <= RST_DEEMPH; // RQ7
			idle_thr <= RST_IDLE_THR;
			sd_ctl <= RST_SD_CTL;
			rsv_a <= RST_RSV;
			rsv_b <= RST_RSV;
			a0_idle <= RST_A0_IDLE;
		end else if (wr_stb) begin
			case (wr_addr)
				OFS_SWING: swing <= wr_data; // RQ1 RQ2 RQ3 RQ4
				OFS_DEEMPH: deemph_ctl <= wr_data[4:0]; // RQ7 RQ16
				OFS_IDLE_THR: idle_thr <= wr_data; // RQ8 RQ9
				OFS_SD_CTL: sd_ctl <= wr_data; // RQ10 RQ11 RQ12
				OFS_RSV_A: rsv_a <= wr_data;
				OFS_RSV_B: rsv_b <= wr_data;
				OFS_A0_IDLE: a0_idle <= wr_data; // RQ13 RQ15
				default: ;
			endcase
		end
	end

	// settings driven to the lane
	assign lane_b3_short_protect_en = swing[SWING_SCP_BIT]; // RQ1
	assign lane_b3_rate_gen12 = swing[SWING_RATE_BIT]; // RQ2
	assign lane_b3_output_swing_level = swing[2:0]; // RQ4
	assign lane_b3_deemphasis_level = deemph_ctl[2:0]; // RQ7
	assign lane_b3_idle_assert_thr = idle_thr[3:2]; // RQ8
	assign lane_b3_idle_deassert_thr = idle_thr[1:0]; // RQ9
	assign sd_high_range = sd_ctl[5:4]; // RQ10
	assign sd_fast_detect = sd_ctl[3:2]; // RQ11
	assign sd_reduced_gain = sd_ctl[1:0]; // RQ12

	// idle muting
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lane_a0_output_mute <= 1'b0;
		end else if (a0_idle[IDLE_AUTO_BIT]) begin
			lane_a0_output_mute <= a0_idle[IDLE_SEL_BIT]; // RQ13 RQ14
		end else begin
			lane_a0_output_mute <= a0_idle_s; // RQ13
		end
	end

	// receiver detection: probe until found, limited mode gives up after the window
	logic [1:0] rx_mode;
	logic probing;
	logic [31:0] probe_cnt;
	logic [5:0] probe_num;
	assign rx_mode = a0_idle[FAR_RECEIVER_PROBE_LSB+1:FAR_RECEIVER_PROBE_LSB];
	assign probing = !a0_rx_s && (rx_mode == FAR_RECEIVER_PROBE_PROBE_FOREVER ||
		(rx_mode == FAR_RECEIVER_PROBE_PROBE_LIMITED && probe_num < PROBE_LIMIT));

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			probe_cnt <= 32'h0;
			probe_num <= 6'h00;
			lane_a0_far_receiver_probe <= 1'b0;
		end else begin
			lane_a0_far_receiver_probe <= 1'b0;
			if (rx_mode == FAR_RECEIVER_PROBE_HIZ || rx_mode == FAR_RECEIVER_PROBE_FIXED_50 || a0_rx_s) begin
				probe_cnt <= 32'h0;
				probe_num <= 6'h00;
			end else if (probing) begin
				if (probe_cnt >= 32'(PROBE_CYCLES - 1)) begin
					probe_cnt <= 32'h0;
					probe_num <= probe_num + 6'h01;
					lane_a0_far_receiver_probe <= 1'b1; // RQ15
				end else begin
					probe_cnt <= probe_cnt + 32'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lane_a0_term_50ohm <= 1'b0;
		end else begin
			case (rx_mode)
				FAR_RECEIVER_PROBE_FIXED_50: lane_a0_term_50ohm <= 1'b1; // RQ15
				FAR_RECEIVER_PROBE_HIZ: lane_a0_term_50ohm <= 1'b0; // RQ15
				default: lane_a0_term_50ohm <= a0_rx_s; // RQ15
			endcase
		end
	end
endmodule

// ==== bench/rlc_regs_checker.sv ====
module rlc_regs_checker #(
	parameter int PROBE_CYCLES = 20
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic smb_scl,
	input wire logic smb_sda_out,
	input wire logic smb_sda_oe_n,
	input wire logic lane_a0_far_rx_present,
	input wire logic lane_a0_idle_seen,
	input wire logic lane_b3_short_protect_en,
	input wire logic lane_b3_rate_gen12,
	input wire logic [2:0] lane_b3_output_swing_level,
	input wire logic [2:0] lane_b3_deemphasis_level,
	input wire logic [1:0] lane_b3_idle_assert_thr,
	input wire logic [1:0] lane_b3_idle_deassert_thr,
	input wire logic [1:0] sd_high_range,
	input wire logic [1:0] sd_fast_detect,
	input wire logic [1:0] sd_reduced_gain,
	input wire logic lane_a0_output_mute,
	input wire logic lane_a0_term_50ohm,
	input wire logic lane_a0_far_receiver_probe
);
	timeunit 1ns;
	timeprecision 100ps;
	int hi, lo, iq, rq, gap, age;
	logic idl_d;
	wire logic [17:0] cfg = {lane_b3_short_protect_en, lane_b3_rate_gen12,
		lane_b3_output_swing_level, lane_b3_deemphasis_level, lane_b3_idle_assert_thr,
		lane_b3_idle_deassert_thr, sd_high_range, sd_fast_detect, sd_reduced_gain};
	// cycle counters so rules can speak of quiet periods
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{hi, lo, iq, rq, age} <= '0;
			gap <= 1000;
			idl_d <= 1'b0;
		end else begin
			hi <= smb_scl ? hi + 1 : 0;
			lo <= smb_scl ? 0 : lo + 1;
			iq <= (lane_a0_idle_seen != idl_d) ? 0 : iq + 1;
			idl_d <= lane_a0_idle_seen;
			rq <= lane_a0_far_rx_present ? rq + 1 : 0;
			gap <= lane_a0_far_receiver_probe ? 1 : gap + 1;
			age <= age + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	chk_cfg_quiet: assert property (hi > 8 |-> $stable(cfg))
		else $error("config moved while scl idle");
	chk_mute_cause: assert property ($changed(lane_a0_output_mute) |-> hi < 9 || iq < 6 || age < 6)
		else $error("mute moved without cause");
	chk_probe_pulse: assert property (lane_a0_far_receiver_probe |=> !lane_a0_far_receiver_probe)
		else $error("probe longer than one cycle");
	chk_probe_gap: assert property (lane_a0_far_receiver_probe |-> gap >= PROBE_CYCLES)
		else $error("probes too close");
	chk_probe_found: assert property (rq > 5 |-> !lane_a0_far_receiver_probe)
		else $error("probe after receiver found");
	chk_probe_term: assert property (lane_a0_far_receiver_probe |-> !lane_a0_term_50ohm)
		else $error("probing while terminated");
	chk_sda_timing: assert property ($changed(smb_sda_oe_n) |-> !smb_scl && lo < 9)
		else $error("sda moved outside scl low");
	chk_sda_open: assert property (smb_sda_out == 1'b0)
		else $error("sda driven high");
endmodule
bind rlc_regs rlc_regs_checker #(.PROBE_CYCLES(PROBE_CYCLES)) rlc_regs_checker_inst (.*);

// ==== bench/rlc_host.sv ====
module rlc_host (
	input wire logic core_clk,
	input wire logic dev_oe_n,
	output logic smb_scl,
	output logic smb_sda_in,
	output logic rd_stb,
	output logic [7:0] rd_q
);
	timeunit 1ns;
	timeprecision 100ps;
	import rlc_pkg::*;
	localparam int H = 12;
	logic hl = 1'b0;
	// pull-up wins when nobody pulls low
	assign smb_sda_in = ~(hl | ~dev_oe_n);
	initial begin
		smb_scl = 1'b1;
		rd_stb = 1'b0;
		rd_q = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		hl = ~b;
		tick(H);
		smb_scl = 1'b1;
		tick(H);
		r = smb_sda_in;
		smb_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(1'b1, a);
	endtask
	task automatic start();
		hl = 1'b0;
		tick(H);
		smb_scl = 1'b1;
		tick(H);
		hl = 1'b1;
		tick(H);
		smb_scl = 1'b0;
	endtask
	task automatic stop();
		hl = 1'b1;
		tick(H);
		smb_scl = 1'b1;
		tick(H);
		hl = 1'b0;
		tick(H);
	endtask
	// one data byte, two when n > 1: d[7:0] first, then d[15:8] at the stepped pointer
	task automatic wr(input logic [6:0] dev, input logic [7:0] o, input logic [15:0] d,
		input int n, output logic [2:0] acks);
		logic [7:0] q;
		logic a;
		start();
		byte_io({dev, 1'b0}, q, acks[2]);
		byte_io(o, q, acks[1]);
		byte_io(d[7:0], q, acks[0]);
		if (n > 1) begin
			byte_io(d[15:8], q, a);
			acks[0] = acks[0] | a;
		end
		stop();
	endtask
	// host acks every byte but the last, which it nacks as the bus requires
	task automatic rd(input logic [7:0] o, input int n, output logic [2:0] acks);
		logic [7:0] q;
		logic a;
		start();
		byte_io({SMB_DEV_ADDR, 1'b0}, q, acks[2]);
		byte_io(o, q, acks[1]);
		start();
		byte_io({SMB_DEV_ADDR, 1'b1}, q, acks[0]);
		for (int k = 1; k <= n; k++) begin
			for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
			bit_io((k < n) ? 1'b0 : 1'b1, a);
			rd_q = q;
			rd_stb = 1'b1;
			tick(1);
			rd_stb = 1'b0;
		end
		stop();
	endtask
endmodule

// ==== bench/tb.sv ====
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rlc_pkg::*;
	localparam int PC = 20;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic smb_scl, smb_sda_in, smb_sda_out, smb_sda_oe_n, rd_stb;
	logic lane_b3_far_rx_present, lane_a0_far_rx_present, lane_a0_idle_seen;
	logic [1:0] lane_b3_observed_line_rate, lane_b3_idle_assert_thr, lane_b3_idle_deassert_thr;
	logic lane_b3_short_protect_en, lane_b3_rate_gen12;
	logic [2:0] lane_b3_output_swing_level, lane_b3_deemphasis_level, acks;
	logic [1:0] sd_high_range, sd_fast_detect, sd_reduced_gain;
	logic lane_a0_output_mute, lane_a0_term_50ohm, lane_a0_far_receiver_probe;
	logic [7:0] rd_q, d, e;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int checked = 0;
	int probes = 0;
	int seed = 32'h5cb2;
	always #2.5 core_clk = ~core_clk;
	rlc_regs #(.PROBE_CYCLES(PC)) rlc_regs_inst (.core_clk, .rstn, .smb_scl, .smb_sda_in,
		.smb_sda_out, .smb_sda_oe_n, .lane_b3_far_rx_present, .lane_b3_observed_line_rate,
		.lane_a0_far_rx_present, .lane_a0_idle_seen, .lane_b3_short_protect_en,
		.lane_b3_rate_gen12, .lane_b3_output_swing_level, .lane_b3_deemphasis_level,
		.lane_b3_idle_assert_thr, .lane_b3_idle_deassert_thr, .sd_high_range, .sd_fast_detect,
		.sd_reduced_gain, .lane_a0_output_mute, .lane_a0_term_50ohm, .lane_a0_far_receiver_probe);
	rlc_host rlc_host_inst (.core_clk(core_clk), .dev_oe_n(smb_sda_oe_n), .smb_scl(smb_scl),
		.smb_sda_in(smb_sda_in), .rd_stb(rd_stb), .rd_q(rd_q));
	always @(posedge core_clk) begin
		if (lane_a0_far_receiver_probe === 1'b1) probes++;
		if (rd_stb) begin
			e = exp_q.pop_front();
			`CHK(rd_q, e)
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic w(input logic [7:0] o, input logic [7:0] v);
		rlc_host_inst.wr(SMB_DEV_ADDR, o, {8'h00, v}, 1, acks);
		`CHK(acks, 3'b000)
	endtask
	task automatic r(input logic [7:0] o, input logic [7:0] v);
		exp_q.push_back(v);
		rlc_host_inst.rd(o, 1, acks);
		`CHK(acks, 3'b000)
	endtask
	task automatic give_verdict();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(100000);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{lane_b3_far_rx_present, lane_b3_observed_line_rate} = 3'b000;
		{lane_a0_far_rx_present, lane_a0_idle_seen} = 2'b00;
		cyc(20);
		rstn = 1'b1;
		cyc(4);
		`CHK({lane_b3_short_protect_en, lane_b3_rate_gen12, lane_b3_output_swing_level}, 5'h15)
		`CHK({lane_b3_deemphasis_level, lane_b3_idle_assert_thr, lane_b3_idle_deassert_thr}, 7'h20)
		`CHK({sd_high_range, sd_fast_detect, sd_reduced_gain}, 6'h0C)
		`CHK({lane_a0_output_mute, lane_a0_term_50ohm, lane_a0_far_receiver_probe}, 3'b000)
		r(OFS_SWING, RST_SWING);
		r(OFS_DEEMPH, {3'b000, RST_DEEMPH});
		r(OFS_SD_CTL, RST_SD_CTL);
		r(OFS_RSV_A, RST_RSV);
		r(OFS_A0_IDLE, RST_A0_IDLE);
		$display("test reset done");
		for (int n = 0; n < 4; n++) begin
			d = 8'($random(seed));
			lane_b3_far_rx_present = d[7];
			lane_b3_observed_line_rate = (n % 3 == 2) ? 2'h3 : 2'(n % 3);
			w(OFS_SWING, {d[7:6], 3'b101, d[2:0]});
			`CHK({lane_b3_short_protect_en, lane_b3_rate_gen12, lane_b3_output_swing_level}, {d[7:6], d[2:0]})
			w(OFS_DEEMPH, {3'b111, 2'b00, d[2:0]});
			`CHK(lane_b3_deemphasis_level, d[2:0])
			r(OFS_DEEMPH, {d[7], lane_b3_observed_line_rate, 2'b00, d[2:0]});
			w(OFS_IDLE_THR, {4'h0, d[3:0]});
			`CHK({lane_b3_idle_assert_thr, lane_b3_idle_deassert_thr}, d[3:0])
			w(OFS_SD_CTL, {2'b00, d[5:0]});
			`CHK({sd_high_range, sd_fast_detect, sd_reduced_gain}, d[5:0])
			r(OFS_IDLE_THR, {4'h0, d[3:0]});
		end
		w(8'h30, 8'h5A);
		r(8'h30, 8'h00);
		rlc_host_inst.wr(7'h11, OFS_IDLE_THR, 16'h000F, 1, acks);
		`CHK(acks, 3'b111)
		r(OFS_IDLE_THR, {4'h0, d[3:0]});
		// burst write and burst read: the pointer steps from 0x27 to 0x28 both ways
		d = 8'($random(seed));
		rlc_host_inst.wr(SMB_DEV_ADDR, OFS_IDLE_THR, {2'b00, d[5:0], 4'h0, d[3:0]}, 2, acks);
		`CHK(acks, 3'b000)
		`CHK({lane_b3_idle_assert_thr, lane_b3_idle_deassert_thr}, d[3:0])
		`CHK({sd_high_range, sd_fast_detect, sd_reduced_gain}, d[5:0])
		exp_q.push_back({4'h0, d[3:0]});
		exp_q.push_back({2'b00, d[5:0]});
		rlc_host_inst.rd(OFS_IDLE_THR, 2, acks);
		`CHK(acks, 3'b000)
		$display("test access done");
		lane_a0_idle_seen = 1'b1;
		w(OFS_A0_IDLE, 8'h00);
		`CHK(lane_a0_output_mute, 1'b1)
		lane_a0_idle_seen = 1'b0;
		cyc(6);
		`CHK(lane_a0_output_mute, 1'b0)
		w(OFS_A0_IDLE, 8'h30);
		`CHK(lane_a0_output_mute, 1'b1)
		lane_a0_idle_seen = 1'b1;
		w(OFS_A0_IDLE, 8'h20);
		`CHK(lane_a0_output_mute, 1'b0)
		$display("test idle done");
		w(OFS_A0_IDLE, 8'h0C);
		probes = 0;
		cyc(3 * PC);
		`CHK({lane_a0_term_50ohm, probes}, {1'b1, 32'd0})
		probes = 0;
		w(OFS_A0_IDLE, 8'h04);
		cyc(52 * PC);
		`CHK({lane_a0_term_50ohm, probes}, {1'b0, 32'(PROBE_WINDOW_MS / PROBE_PERIOD_MS)})
		w(OFS_A0_IDLE, 8'h00);
		probes = 0;
		cyc(3 * PC);
		`CHK({lane_a0_term_50ohm, probes}, {1'b0, 32'd0})
		w(OFS_A0_IDLE, 8'h08);
		cyc(60 * PC);
		`CHK(probes > 50, 1'b1)
		lane_a0_far_rx_present = 1'b1;
		cyc(5);
		probes = 0;
		cyc(3 * PC);
		`CHK({lane_a0_term_50ohm, probes}, {1'b1, 32'd0})
		$display("test probe done");
		give_verdict();
	end
endmodule
